/* include/rct_defs.svh */
// Register offsets, field positions, reset values and divider counts of the timer
`ifndef RCT_DEFS_SVH
`define RCT_DEFS_SVH
// ----------------------------------------------------------------------
// Register offsets
// ----------------------------------------------------------------------
`define RCT_OFF_CTRL   3'h0
`define RCT_OFF_CNTLO  3'h1
`define RCT_OFF_CNTHI  3'h2
`define RCT_OFF_RLDLO  3'h3
`define RCT_OFF_RLDHI  3'h4
`define RCT_OFF_CKSEL  3'h5
// ----------------------------------------------------------------------
// Control field positions
// ----------------------------------------------------------------------
`define RCT_B_HIFLAG   7
`define RCT_B_LOFLAG   6
`define RCT_B_LOIEN    5
`define RCT_B_CAPEN    4
`define RCT_B_SPLIT    3
`define RCT_B_RUN      2
`define RCT_B_CSS      1
`define RCT_B_XCLK     0
`define RCT_CKSEL_HI   1
`define RCT_CKSEL_LO   0
// ----------------------------------------------------------------------
// Values and counts
// ----------------------------------------------------------------------
`define RCT_CTRL_RST   8'h00
`define RCT_CKSEL_RST  2'h0
`define RCT_ZERO8      8'h00
`define RCT_ONE8       8'h01
`define RCT_MAX8       8'hFF
`define RCT_ONE16      16'h0001
`define RCT_MAX16      16'hFFFF
`define RCT_SYS_DIV    12
`define RCT_EXT_DIV    8
`endif

/* include/rct_pkg.sv */
// State types of the timer modules
package rct_pkg;
    // Main timer state
    typedef struct packed {
        logic [7:0] ctrl;
        logic [7:0] cntLo;
        logic [7:0] cntHi;
        logic [7:0] rldLo;
        logic [7:0] rldHi;
        logic [1:0] ckSel;
        logic [7:0] rdata;
    } rct_main_t;
    // Divider state
    typedef struct packed {
        logic [7:0] sysCnt;
        logic [7:0] extCnt;
        logic       tickSys;
        logic       tickExt;
    } rct_tick_t;
    // Synchroniser state
    typedef struct packed {
        logic [2:0] sh;
    } rct_sync_t;
endpackage

/* rtl/rct_edge_sync.sv */
// Two-stage synchroniser with edge pulses
`timescale 1ns/1ps
module rct_edge_sync (
    // Clock and reset
    input  wire logic clk,
    input  wire logic rstn,
    // Asynchronous input
    input  wire logic asyncIn,
    // Edge pulses
    output logic      risePulse,
    output logic      fallPulse
);
    rct_pkg::rct_sync_t st_reg;
    rct_pkg::rct_sync_t st_next;

    // Shift chain; only stage 1 and 2 feed the edge compare
    always_comb begin
        st_next    = st_reg;
        st_next.sh = {st_reg.sh[1], st_reg.sh[0], asyncIn};
    end

    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            st_reg <= '0;
        end else begin
            st_reg <= st_next;
        end
    end

    // Edge pulses from the synchronised level
    assign risePulse = st_reg.sh[1] & ~st_reg.sh[2];
    assign fallPulse = ~st_reg.sh[1] & st_reg.sh[2];
endmodule

/* rtl/rct_tick_gen.sv */
// Count-enable ticks: system clock / SYS_DIV and external edges / EXT_DIV
`timescale 1ns/1ps
`include "rct_defs.svh"
module rct_tick_gen #(
    parameter int SYS_DIV = `RCT_SYS_DIV,
    parameter int EXT_DIV = `RCT_EXT_DIV
) (
    // Clock and reset
    input  wire logic clk,
    input  wire logic rstn,
    // Synchronised external rising edge
    input  wire logic extRise,
    // Ticks
    output logic      tickSys,
    output logic      tickExt
);
    rct_pkg::rct_tick_t st_reg;
    rct_pkg::rct_tick_t st_next;
    localparam logic [7:0] SYS_LAST = 8'(SYS_DIV - 1);
    localparam logic [7:0] EXT_LAST = 8'(EXT_DIV - 1);

    // Free divider and external edge divider
    always_comb begin
        st_next         = st_reg;
        st_next.tickSys = (st_reg.sysCnt == SYS_LAST);
        st_next.sysCnt  = (st_reg.sysCnt == SYS_LAST) ? `RCT_ZERO8
                                                      : st_reg.sysCnt + `RCT_ONE8;
        st_next.tickExt = extRise && (st_reg.extCnt == EXT_LAST);
        if (extRise) begin
            st_next.extCnt = (st_reg.extCnt == EXT_LAST) ? `RCT_ZERO8
                                                         : st_reg.extCnt + `RCT_ONE8;
        end
    end

    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            st_reg <= '0;
        end else begin
            st_reg <= st_next;
        end
    end

    assign tickSys = st_reg.tickSys;
    assign tickExt = st_reg.tickExt;

    default clocking cb @(posedge clk); endclocking
    default disable iff (!rstn);

    AST_DIV12_GAP: assert property (tickSys |=> !tickSys [*8])
        else $error("divided tick too close");
    AST_EXT_CAUSE: assert property (tickExt |-> $past(extRise))
        else $error("external tick without synchronised edge");
endmodule

/* rtl/rct_timer.sv */
// Reload and capture timer with register port
`timescale 1ns/1ps
`include "rct_defs.svh"
// Behaviour
// - Two 8-bit bytes with own reloads
// - Split, capture, source bits select mode
// - Clocks: system, system/12, external/8
// - External divided clock synchronised first
// - 16-bit wrap reloads, sets high flag
// - 16-bit overflow raises enabled interrupt
// - Low-byte overflow interrupts when enabled
// - Split: each byte reloads on overflow
// - Split: run gates high byte only
// - Split: per-byte clock select bits
// - Split: per-byte overflow flags
// - Split: interrupt on high, optionally low
// - Flags cleared by software only
// - Source bit picks frame start or slow fall
// - Capture 16-bit: wrap, copy, interrupt
// - Capture split: bytes wrap, copy, interrupt
// - Control register layout, reset zero
// - Low flag set in every mode
module rct_timer #(
    parameter int SYS_DIV = `RCT_SYS_DIV,
    parameter int EXT_DIV = `RCT_EXT_DIV
) (
    // Clock and reset
    input  wire logic       clk,
    input  wire logic       rstn,
    // Register port
    input  wire logic [2:0] regAddr,
    input  wire logic [7:0] regWdata,
    input  wire logic       regWr,
    input  wire logic       regRd,
    output logic      [7:0] regRdata,
    // Event inputs from other domains
    input  wire logic       extOscIn,
    input  wire logic       usbSofIn,
    input  wire logic       slowOscIn,
    // Interrupt request
    input  wire logic       timerIrqEnable,
    output logic            irqReq
);
    // ------------------------------------------------------------------
    // Declarations
    // ------------------------------------------------------------------
    rct_pkg::rct_main_t st_reg;
    rct_pkg::rct_main_t st_next;
    logic        extRise;
    logic        sofRise;
    logic        slowFall;
    logic        tickSys;
    logic        tickExt;
    logic        divTick;
    logic        tickLo;
    logic        tickHi;
    logic        split;
    logic        capOn;
    logic        run;
    logic        adv16;
    logic        loAdv;
    logic        hiAdv;
    logic        capEv;
    logic        setHi;
    logic        setLo;
    logic [15:0] cnt16;
    logic [15:0] rld16;

    // ------------------------------------------------------------------
    // Synchronisers and dividers
    // ------------------------------------------------------------------
    rct_edge_sync uExtSync (
        .clk       (clk),
        .rstn      (rstn),
        .asyncIn   (extOscIn),
        .risePulse (extRise),
        .fallPulse ()
    );
    rct_edge_sync uSofSync (
        .clk       (clk),
        .rstn      (rstn),
        .asyncIn   (usbSofIn),
        .risePulse (sofRise),
        .fallPulse ()
    );
    rct_edge_sync uSlowSync (
        .clk       (clk),
        .rstn      (rstn),
        .asyncIn   (slowOscIn),
        .risePulse (),
        .fallPulse (slowFall)
    );
    rct_tick_gen #(
        .SYS_DIV (SYS_DIV),
        .EXT_DIV (EXT_DIV)
    ) uTick (
        .clk     (clk),
        .rstn    (rstn),
        .extRise (extRise),
        .tickSys (tickSys),
        .tickExt (tickExt)
    );

    // ------------------------------------------------------------------
    // Mode decode and count enables
    // ------------------------------------------------------------------
    assign split   = st_reg.ctrl[`RCT_B_SPLIT];
    assign capOn   = st_reg.ctrl[`RCT_B_CAPEN];
    assign run     = st_reg.ctrl[`RCT_B_RUN];
    assign divTick = st_reg.ctrl[`RCT_B_XCLK] ? tickExt : tickSys;
    assign tickLo  = st_reg.ckSel[`RCT_CKSEL_LO] | divTick;
    assign tickHi  = st_reg.ckSel[`RCT_CKSEL_HI] | divTick;
    assign adv16   = run & tickLo;
    assign loAdv   = split ? tickLo : adv16;
    assign hiAdv   = split ? (run & tickHi) : (adv16 & (st_reg.cntLo == `RCT_MAX8));
    // Capture event from the selected source
    assign capEv   = capOn & (st_reg.ctrl[`RCT_B_CSS] ? slowFall : sofRise);
    assign cnt16   = {st_reg.cntHi, st_reg.cntLo};
    assign rld16   = {st_reg.rldHi, st_reg.rldLo};

    // ------------------------------------------------------------------
    // Next-state logic
    // ------------------------------------------------------------------
    always_comb begin
        st_next = st_reg;
        setHi   = 1'b0;
        setLo   = 1'b0;
        // Counting
        if (!split) begin
            if (adv16) begin
                if (cnt16 == `RCT_MAX16) begin
                    {st_next.cntHi, st_next.cntLo} = capOn ? 16'h0000 : rld16;
                    setHi = 1'b1;
                end else begin
                    {st_next.cntHi, st_next.cntLo} = cnt16 + `RCT_ONE16;
                end
                if (st_reg.cntLo == `RCT_MAX8) begin
                    setLo = 1'b1;
                end
            end
        end else begin
            if (loAdv) begin
                if (st_reg.cntLo == `RCT_MAX8) begin
                    st_next.cntLo = capOn ? `RCT_ZERO8 : st_reg.rldLo;
                    setLo = 1'b1;
                end else begin
                    st_next.cntLo = st_reg.cntLo + `RCT_ONE8;
                end
            end
            if (hiAdv) begin
                if (st_reg.cntHi == `RCT_MAX8) begin
                    st_next.cntHi = capOn ? `RCT_ZERO8 : st_reg.rldHi;
                    setHi = 1'b1;
                end else begin
                    st_next.cntHi = st_reg.cntHi + `RCT_ONE8;
                end
            end
        end
        // Capture copies both bytes and flags an interrupt
        if (capEv) begin
            st_next.rldLo = st_reg.cntLo;
            st_next.rldHi = st_reg.cntHi;
            setHi = 1'b1;
        end
        // Software writes override hardware updates except flag sets
        if (regWr) begin
            case (regAddr)
                `RCT_OFF_CTRL: begin
                    st_next.ctrl = regWdata;
                end
                `RCT_OFF_CNTLO: begin
                    st_next.cntLo = regWdata;
                end
                `RCT_OFF_CNTHI: begin
                    st_next.cntHi = regWdata;
                end
                `RCT_OFF_RLDLO: begin
                    st_next.rldLo = regWdata;
                end
                `RCT_OFF_RLDHI: begin
                    st_next.rldHi = regWdata;
                end
                `RCT_OFF_CKSEL: begin
                    st_next.ckSel = regWdata[1:0];
                end
                default: begin
                end
            endcase
        end
        // Hardware sets win over a same-cycle software clear
        st_next.ctrl[`RCT_B_HIFLAG] = st_next.ctrl[`RCT_B_HIFLAG] | setHi;
        st_next.ctrl[`RCT_B_LOFLAG] = st_next.ctrl[`RCT_B_LOFLAG] | setLo;
        // Read data for the following cycle only
        st_next.rdata = `RCT_ZERO8;
        if (regRd) begin
            case (regAddr)
                `RCT_OFF_CTRL:  st_next.rdata = st_reg.ctrl;
                `RCT_OFF_CNTLO: st_next.rdata = st_reg.cntLo;
                `RCT_OFF_CNTHI: st_next.rdata = st_reg.cntHi;
                `RCT_OFF_RLDLO: st_next.rdata = st_reg.rldLo;
                `RCT_OFF_RLDHI: st_next.rdata = st_reg.rldHi;
                `RCT_OFF_CKSEL: st_next.rdata = {6'h00, st_reg.ckSel};
                default:        st_next.rdata = `RCT_ZERO8;
            endcase
        end
    end

    // State register
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            st_reg       <= '0;
            st_reg.ctrl  <= `RCT_CTRL_RST;
            st_reg.ckSel <= `RCT_CKSEL_RST;
        end else begin
            st_reg <= st_next;
        end
    end

    // ------------------------------------------------------------------
    // Outputs
    // ------------------------------------------------------------------
    assign regRdata = st_reg.rdata;
    // Level request while an enabled flag stands
    assign irqReq = timerIrqEnable & (st_reg.ctrl[`RCT_B_HIFLAG] |
                    (st_reg.ctrl[`RCT_B_LOIEN] & st_reg.ctrl[`RCT_B_LOFLAG]));

    // ------------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------------
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rstn);

    AST_WRAP16_RELOAD: assert property (
        !split && !capOn && adv16 && cnt16 == `RCT_MAX16 && !regWr
        |=> st_reg.ctrl[`RCT_B_HIFLAG] && cnt16 == $past(rld16))
        else $error("16-bit wrap did not reload or flag");
    AST_LO_FLAG: assert property (
        loAdv && st_reg.cntLo == `RCT_MAX8 && !regWr |=> st_reg.ctrl[`RCT_B_LOFLAG])
        else $error("low overflow flag not set");
    AST_RUN_HOLD: assert property (
        !split && !run && !regWr |=> cnt16 == $past(cnt16))
        else $error("16-bit counter moved while stopped");
    AST_SPLIT_HI_HOLD: assert property (
        split && !run && !regWr |=> st_reg.cntHi == $past(st_reg.cntHi))
        else $error("high byte moved while stopped in split mode");
    AST_SPLIT_RELOAD: assert property (
        split && !capOn && hiAdv && st_reg.cntHi == `RCT_MAX8 && !regWr
        |=> st_reg.cntHi == $past(st_reg.rldHi) && st_reg.ctrl[`RCT_B_HIFLAG])
        else $error("split high byte did not reload");
    AST_CAPTURE: assert property (
        capEv && !regWr |=> rld16 == $past(cnt16) && st_reg.ctrl[`RCT_B_HIFLAG])
        else $error("capture did not copy counter");
    AST_FLAG_STICKY: assert property (
        st_reg.ctrl[`RCT_B_HIFLAG] && !(regWr && regAddr == `RCT_OFF_CTRL)
        |=> st_reg.ctrl[`RCT_B_HIFLAG])
        else $error("high flag cleared without a write");
    AST_IRQ_FOLLOWS: assert property (
        timerIrqEnable && $rose(st_reg.ctrl[`RCT_B_HIFLAG]) |-> irqReq)
        else $error("interrupt missing on overflow flag");
    AST_WRITE_WINS: assert property (
        regWr && regAddr == `RCT_OFF_CNTLO |=> st_reg.cntLo == $past(regWdata))
        else $error("software write lost");
    AST_READ_CTRL: assert property (
        regRd && regAddr == `RCT_OFF_CTRL |=> regRdata == $past(st_reg.ctrl))
        else $error("control read data wrong");

    // Split-mode count and clock checks, low-flag interrupt check in any mode
    AST_SPLIT_LO_RELOAD: assert property (
        split && !capOn && loAdv && st_reg.cntLo == `RCT_MAX8 && !regWr
        |=> st_reg.cntLo == $past(st_reg.rldLo))
        else $error("split low byte did not reload");
    AST_LO_FREE_RUN: assert property (
        split && !run && tickLo && st_reg.cntLo != `RCT_MAX8 && !regWr
        |=> st_reg.cntLo == $past(st_reg.cntLo) + `RCT_ONE8)
        else $error("low byte did not count with run clear");
    AST_LO_CLK_SEL: assert property (
        split && !st_reg.ckSel[`RCT_CKSEL_LO] && !divTick && !regWr
        |=> st_reg.cntLo == $past(st_reg.cntLo))
        else $error("low byte moved without its selected tick");
    AST_LO_IRQ: assert property (
        timerIrqEnable && st_reg.ctrl[`RCT_B_LOIEN] && st_reg.ctrl[`RCT_B_LOFLAG] |-> irqReq)
        else $error("interrupt missing on enabled low flag");

    // Capture-mode wrap and source checks
    AST_CAP_WRAP16: assert property (
        !split && capOn && adv16 && cnt16 == `RCT_MAX16 && !regWr
        |=> cnt16 == {`RCT_ZERO8, `RCT_ZERO8})
        else $error("16-bit capture count did not wrap to zero");
    AST_CAP_SPLIT_WRAP: assert property (
        split && capOn && loAdv && st_reg.cntLo == `RCT_MAX8 && !regWr
        |=> st_reg.cntLo == `RCT_ZERO8)
        else $error("split capture low byte did not wrap to zero");
    AST_CAP_SOURCE: assert property (
        capOn && st_reg.ctrl[`RCT_B_CSS] && sofRise && !slowFall && !regWr
        |=> rld16 == $past(rld16))
        else $error("capture taken from the unselected source");

    COV_WRAP16: cover property (!split && adv16 && cnt16 == `RCT_MAX16);
    COV_SPLIT_HI: cover property (split && hiAdv && st_reg.cntHi == `RCT_MAX8);
    COV_CAPTURE: cover property (capEv ##1 irqReq);
    COV_LO_IRQ: cover property (st_reg.ctrl[`RCT_B_LOIEN] && $rose(st_reg.ctrl[`RCT_B_LOFLAG]));
endmodule

/* tb/rct_testbench.sv */
// Self-checking testbench of the reload and capture timer
`timescale 1ns/1ps
`include "rct_defs.svh"
module testbench;
    // ------------------------------------------------------------------
    // Signals
    // ------------------------------------------------------------------
    logic       clk;
    logic       rstn;
    logic [2:0] regAddr;
    logic [7:0] regWdata;
    logic       regWr;
    logic       regRd;
    logic [7:0] regRdata;
    logic       extOscIn;
    logic       usbSofIn;
    logic       slowOscIn;
    logic       timerIrqEnable;
    logic       irqReq;
    int         num_errors;
    int         compares;
    int         cycles;
    logic [7:0] v0;
    logic [7:0] v1;

    // Device under test
    rct_timer #(.SYS_DIV(12), .EXT_DIV(8)) dut (
        .clk(clk), .rstn(rstn), .regAddr(regAddr), .regWdata(regWdata),
        .regWr(regWr), .regRd(regRd), .regRdata(regRdata), .extOscIn(extOscIn),
        .usbSofIn(usbSofIn), .slowOscIn(slowOscIn), .timerIrqEnable(timerIrqEnable),
        .irqReq(irqReq)
    );

    // ------------------------------------------------------------------
    // Clock and hang guard
    // ------------------------------------------------------------------
    initial begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end

    // Cuts a hang short well after the longest sequence
    always @(posedge clk) begin
        cycles <= cycles + 1;
        if (cycles == 5000) begin
            num_errors++;
            end_of_test();
        end
    end

    // ------------------------------------------------------------------
    // Shared tasks
    // ------------------------------------------------------------------
    task automatic end_of_test();
        $display("errors %0d compares %0d", num_errors, compares);
        if (num_errors == 0 && compares > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask

    task automatic check(input string name, input logic [7:0] seen, input logic [7:0] exp);
        compares++;
        if (seen !== exp) begin
            num_errors++;
            $display("[FAIL] %s expected %h seen %h", name, exp, seen);
        end
    endtask

    // One-cycle write strobe
    task automatic wrReg(input logic [2:0] a, input logic [7:0] d);
        @(posedge clk);
        regWr    <= 1'b1;
        regAddr  <= a;
        regWdata <= d;
        @(posedge clk);
        regWr <= 1'b0;
    endtask

    // One-cycle read strobe, data taken in the following cycle
    task automatic rdReg(input logic [2:0] a, output logic [7:0] d);
        @(posedge clk);
        regRd   <= 1'b1;
        regAddr <= a;
        @(posedge clk);
        regRd <= 1'b0;
        #1;
        d = regRdata;
    endtask

    task automatic expReg(input string name, input logic [2:0] a, input logic [7:0] e);
        logic [7:0] v;
        rdReg(a, v);
        check(name, v, e);
    endtask

    task automatic loadCounts(input logic [15:0] cnt, input logic [15:0] rld);
        wrReg(`RCT_OFF_CNTLO, cnt[7:0]);
        wrReg(`RCT_OFF_CNTHI, cnt[15:8]);
        wrReg(`RCT_OFF_RLDLO, rld[7:0]);
        wrReg(`RCT_OFF_RLDHI, rld[15:8]);
    endtask

    // ------------------------------------------------------------------
    // Scenarios
    // ------------------------------------------------------------------
    task automatic testResetAndMap();
        expReg("ctrl reset", `RCT_OFF_CTRL, 8'h00);
        expReg("cksel reset", `RCT_OFF_CKSEL, 8'h00);
        expReg("cntlo reset", `RCT_OFF_CNTLO, 8'h00);
        expReg("rldhi reset", `RCT_OFF_RLDHI, 8'h00);
        wrReg(3'h7, 8'hFF);
        expReg("unmapped read", 3'h7, 8'h00);
        expReg("ctrl after unmapped", `RCT_OFF_CTRL, 8'h00);
        wrReg(`RCT_OFF_CTRL, 8'hE3);
        expReg("ctrl readback", `RCT_OFF_CTRL, 8'hE3);
        wrReg(`RCT_OFF_CTRL, 8'h00);
        #1;
        check("irq cleared", irqReq, 1'b0);
    endtask

    task automatic testSixteenBit();
        wrReg(`RCT_OFF_CKSEL, 8'h03);
        loadCounts(16'hFFFD, 16'hAB12);
        wrReg(`RCT_OFF_CTRL, 8'h04);
        repeat (2) @(posedge clk);
        expReg("ctrl flags", `RCT_OFF_CTRL, 8'hC4);
        check("irq on overflow", irqReq, 1'b1);
        wrReg(`RCT_OFF_CTRL, 8'hC0);
        expReg("cnt lo after reload", `RCT_OFF_CNTLO, 8'h15);
        expReg("cnt hi after reload", `RCT_OFF_CNTHI, 8'hAB);
        expReg("cnt lo stopped", `RCT_OFF_CNTLO, 8'h15);
        @(posedge clk);
        timerIrqEnable <= 1'b0;
        @(posedge clk);
        #1;
        check("irq masked", irqReq, 1'b0);
        @(posedge clk);
        timerIrqEnable <= 1'b1;
        wrReg(`RCT_OFF_CTRL, 8'h00);
        #1;
        check("irq after clear", irqReq, 1'b0);
    endtask

    task automatic testSplit();
        loadCounts(16'hFEFE, 16'hE0F0);
        wrReg(`RCT_OFF_CTRL, 8'h28);
        repeat (2) @(posedge clk);
        expReg("split lo reload", `RCT_OFF_CNTLO, 8'hF1);
        expReg("split lo flag", `RCT_OFF_CTRL, 8'h68);
        check("irq low byte", irqReq, 1'b1);
        expReg("split hi idle", `RCT_OFF_CNTHI, 8'hFE);
        wrReg(`RCT_OFF_CNTLO, 8'h40);
        expReg("write wins", `RCT_OFF_CNTLO, 8'h41);
        wrReg(`RCT_OFF_CTRL, 8'h2C);
        @(posedge clk);
        expReg("split hi reload", `RCT_OFF_CNTHI, 8'hE0);
        rdReg(`RCT_OFF_CTRL, v0);
        check("split hi flag", v0 & 8'h80, 8'h80);
        wrReg(`RCT_OFF_CTRL, 8'h00);
    endtask

    task automatic testCapture();
        loadCounts(16'h3456, 16'h0000);
        wrReg(`RCT_OFF_CTRL, 8'h10);
        usbSofIn <= 1'b1;
        repeat (6) @(posedge clk);
        expReg("sof cap lo", `RCT_OFF_RLDLO, 8'h56);
        expReg("sof cap hi", `RCT_OFF_RLDHI, 8'h34);
        expReg("sof cap flag", `RCT_OFF_CTRL, 8'h90);
        @(posedge clk);
        usbSofIn <= 1'b0;
        loadCounts(16'h789A, 16'h3456);
        wrReg(`RCT_OFF_CTRL, 8'h12);
        usbSofIn  <= 1'b1;
        slowOscIn <= 1'b1;
        repeat (6) @(posedge clk);
        expReg("no cap on sof or rise", `RCT_OFF_RLDLO, 8'h56);
        @(posedge clk);
        slowOscIn <= 1'b0;
        repeat (6) @(posedge clk);
        expReg("osc cap lo", `RCT_OFF_RLDLO, 8'h9A);
        expReg("osc cap hi", `RCT_OFF_RLDHI, 8'h78);
        expReg("osc cap flag", `RCT_OFF_CTRL, 8'h92);
        @(posedge clk);
        usbSofIn <= 1'b0;
        wrReg(`RCT_OFF_CTRL, 8'h00);
        // Split capture: bytes wrap to zero, not to the reload value
        loadCounts(16'hFFFE, 16'h1111);
        wrReg(`RCT_OFF_CTRL, 8'h1C);
        expReg("split cap wrap hi", `RCT_OFF_CNTHI, 8'h00);
        expReg("split cap flags", `RCT_OFF_CTRL, 8'hDC);
        wrReg(`RCT_OFF_CTRL, 8'h00);
    endtask

    task automatic testClockSources();
        loadCounts(16'h0000, 16'h0000);
        wrReg(`RCT_OFF_CKSEL, 8'h01);
        wrReg(`RCT_OFF_CTRL, 8'h0C);
        rdReg(`RCT_OFF_CNTHI, v0);
        repeat (58) @(posedge clk);
        rdReg(`RCT_OFF_CNTHI, v1);
        check("hi sys div 12", v1 - v0, 8'h05);
        wrReg(`RCT_OFF_CKSEL, 8'h02);
        wrReg(`RCT_OFF_CTRL, 8'h0D);
        rdReg(`RCT_OFF_CNTLO, v0);
        repeat (16) begin
            repeat (3) @(posedge clk);
            extOscIn <= 1'b1;
            repeat (3) @(posedge clk);
            extOscIn <= 1'b0;
        end
        repeat (10) @(posedge clk);
        rdReg(`RCT_OFF_CNTLO, v1);
        check("lo ext div 8", v1 - v0, 8'h02);
        wrReg(`RCT_OFF_CTRL, 8'h00);
    endtask

    // ------------------------------------------------------------------
    // Main sequence
    // ------------------------------------------------------------------
    initial begin
        num_errors     = 0;
        compares       = 0;
        cycles         = 0;
        rstn           = 1'b0;
        regAddr        = 3'h0;
        regWdata       = 8'h00;
        regWr          = 1'b0;
        regRd          = 1'b0;
        extOscIn       = 1'b0;
        usbSofIn       = 1'b0;
        slowOscIn      = 1'b0;
        timerIrqEnable = 1'b1;
        repeat (8) @(posedge clk);
        rstn <= 1'b1;
        testResetAndMap();
        testSixteenBit();
        testSplit();
        testCapture();
        testClockSources();
        end_of_test();
    end
endmodule
